// *** rtl/bld_backlight_ctrl.sv ***
// Backlight enable, serial register access, duty filtering and current ramp
`timescale 1ns/1ps
`include "bld_defines.svh"
module bld_backlight_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        hardware_enable_pin_i,
  input  wire logic        pwm_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic      [10:0] sink_level_o,
  output logic             sink_enable_o,
  output logic      [4:0]  full_scale_current_o,
  output logic      [2:0]  channel_enable_o,
  output logic             standby_o
);
  logic                     rst_meta;
  logic                     rst_n;
  logic [3:0]               pin_s;
  logic                     hardware_enable_pin_s;
  logic                     pwm_s;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_q;
  logic                     sda_q;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     bus_start;
  logic                     bus_stop;
  bld_pkg::bld_i2c_state_e  state;
  logic [3:0]               bit_cnt;
  logic [7:0]               rx_sh;
  logic [7:0]               tx_sh;
  logic [7:0]               ptr;
  logic                     rd_mode;
  logic                     nack;
  logic [7:0]               rd_byte;
  logic                     wr_en;
  logic [7:0]               mode_reg;
  logic [7:0]               pwm_reg;
  logic [7:0]               ramp_reg;
  logic [7:0]               ratio_lsb;
  logic [7:0]               ratio_msb;
  logic [10:0]              ratio;
  bld_pkg::bld_duty_t       applied;
  logic                     dir_up;
  logic [10:0]              hyst_thr;
  logic [10:0]              target;
  logic [11:0]              tick_cnt;
  logic [11:0]              tick_lim;
  logic                     tick;
  logic [10:0]              ramp_lvl;
  logic [22:0]              prod;

  bld_duty_if dif ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  bld_sync2 #(
    .W (4)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .d_i     ({hardware_enable_pin_i, pwm_i, scl_i, sda_i}),
    .q_o     (pin_s)
  );

  assign hardware_enable_pin_s = pin_s[3];
  assign pwm_s  = pin_s[2];
  assign scl_s  = pin_s[1];
  assign sda_s  = pin_s[0];

  // Bus line edges, taken from the synchronised copies only
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign wr_en     = hardware_enable_pin_s & scl_fall & (state == bld_pkg::BLD_WDATA) & (bit_cnt == 4'h8);
  assign sda_o     = 1'b0;
  assign standby_o = hardware_enable_pin_s;

  // Read data for the current pointer; unmapped offsets read zero
  always_comb begin
    case (ptr)
      `BLD_REG_MODE:      rd_byte = mode_reg;
      `BLD_REG_RATIO_LSB: rd_byte = ratio_lsb;
      `BLD_REG_RATIO_MSB: rd_byte = ratio_msb;
      `BLD_REG_PWM:       rd_byte = pwm_reg;
      `BLD_REG_RAMP:      rd_byte = ramp_reg;
      default:            rd_byte = 8'h00;
    endcase
  end

  // Serial slave: address, pointer, write bytes, read bytes with auto-increment
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state    <= bld_pkg::BLD_IDLE;
      bit_cnt  <= 4'h0;
      rx_sh    <= 8'h00;
      tx_sh    <= 8'h00;
      ptr      <= 8'h00;
      rd_mode  <= 1'b0;
      nack     <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (!hardware_enable_pin_s) begin
      state    <= bld_pkg::BLD_IDLE;
      bit_cnt  <= 4'h0;
      ptr      <= 8'h00;
      sda_oe_o <= 1'b0;
    end else if (bus_start) begin
      state    <= bld_pkg::BLD_ADDR;
      bit_cnt  <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (bus_stop) begin
      state    <= bld_pkg::BLD_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        bld_pkg::BLD_ADDR, bld_pkg::BLD_REG, bld_pkg::BLD_WDATA: begin
          if (scl_rise) begin
            rx_sh   <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == bld_pkg::BLD_ADDR) begin
              if (rx_sh[7:1] == `BLD_I2C_ADDR) begin
                rd_mode  <= rx_sh[0];
                sda_oe_o <= 1'b1;
                state    <= bld_pkg::BLD_ADDR_ACK;
              end else begin
                state <= bld_pkg::BLD_IDLE; // Other device addressed
              end
            end else if (state == bld_pkg::BLD_REG) begin
              ptr      <= rx_sh;
              sda_oe_o <= 1'b1;
              state    <= bld_pkg::BLD_REG_ACK;
            end else begin
              ptr      <= ptr + 8'h01;
              sda_oe_o <= 1'b1;
              state    <= bld_pkg::BLD_WDATA_ACK;
            end
          end
        end
        bld_pkg::BLD_ADDR_ACK, bld_pkg::BLD_RDATA_ACK: begin
          if (scl_rise) begin
            nack <= sda_s;
          end else if (scl_fall) begin
            if (state == bld_pkg::BLD_ADDR_ACK && !rd_mode) begin
              sda_oe_o <= 1'b0;
              state    <= bld_pkg::BLD_REG;
            end else if (state == bld_pkg::BLD_RDATA_ACK && nack) begin
              sda_oe_o <= 1'b0;
              state    <= bld_pkg::BLD_IDLE;
            end else begin
              // Open drain: enable pulls the line low for a zero bit
              sda_oe_o <= ~rd_byte[7];
              tx_sh    <= {rd_byte[6:0], 1'b0};
              bit_cnt  <= 4'h1;
              state    <= bld_pkg::BLD_RDATA;
            end
          end
        end
        bld_pkg::BLD_REG_ACK, bld_pkg::BLD_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            state    <= bld_pkg::BLD_WDATA;
          end
        end
        bld_pkg::BLD_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              ptr      <= ptr + 8'h01;
              state    <= bld_pkg::BLD_RDATA_ACK;
            end else begin
              sda_oe_o <= ~tx_sh[7];
              tx_sh    <= {tx_sh[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Register file; shutdown returns every field to its default
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg  <= `BLD_MODE_RESET;
      pwm_reg   <= `BLD_PWM_RESET;
      ramp_reg  <= `BLD_RAMP_RESET;
      ratio_lsb <= `BLD_RATIO_LSB_RESET;
      ratio_msb <= `BLD_RATIO_MSB_RESET;
      ratio     <= {`BLD_RATIO_MSB_RESET, 3'h7};
    end else if (!hardware_enable_pin_s) begin
      mode_reg  <= `BLD_MODE_RESET;
      pwm_reg   <= `BLD_PWM_RESET;
      ramp_reg  <= `BLD_RAMP_RESET;
      ratio_lsb <= `BLD_RATIO_LSB_RESET;
      ratio_msb <= `BLD_RATIO_MSB_RESET;
      ratio     <= {`BLD_RATIO_MSB_RESET, 3'h7};
    end else if (wr_en) begin
      case (ptr)
        `BLD_REG_MODE:      mode_reg  <= rx_sh;
        `BLD_REG_RATIO_LSB: ratio_lsb <= rx_sh;
        `BLD_REG_RATIO_MSB: begin
          // Low bits alone do not move the ratio until the high byte lands
          ratio_msb <= rx_sh;
          ratio     <= {rx_sh, ratio_lsb[`BLD_RATIO_LSB_HI:0]};
        end
        `BLD_REG_PWM:       pwm_reg   <= rx_sh;
        `BLD_REG_RAMP:      ramp_reg  <= rx_sh;
        default:            ratio     <= ratio;
      endcase
    end
  end

  assign full_scale_current_o = mode_reg[`BLD_MODE_FS_HI:`BLD_MODE_FS_LO];
  assign channel_enable_o     = pwm_reg[`BLD_PWM_CH_HI:`BLD_PWM_CH_LO];

  // Duty measurement runs only while dimming is on
  assign dif.enable = hardware_enable_pin_s & pwm_reg[`BLD_PWM_EN_BIT];
  assign dif.sample = pwm_s ^ pwm_reg[`BLD_PWM_POL_BIT];

  bld_duty_meas u_meas (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .dif     (dif)
  );

  assign hyst_thr = {7'h00, pwm_reg[`BLD_PWM_HYST_HI:`BLD_PWM_HYST_LO], 1'b0};

  // Hysteresis: same direction follows freely, a reversal must clear the threshold
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      applied <= 11'h000;
      dir_up  <= 1'b1;
    end else if (!hardware_enable_pin_s) begin
      applied <= 11'h000;
      dir_up  <= 1'b1;
    end else if (dif.duty_valid) begin
      if (dif.duty > applied) begin
        if (dir_up || (dif.duty - applied) >= hyst_thr) begin
          applied <= dif.duty;
          dir_up  <= 1'b1;
        end
      end else if (dif.duty < applied) begin
        if (!dir_up || (applied - dif.duty) >= hyst_thr) begin
          applied <= dif.duty;
          dir_up  <= 1'b0;
        end
      end
    end
  end

  // Target: zero outside backlight mode, full duty with dimming off
  always_comb begin
    if (!mode_reg[`BLD_MODE_BL_BIT]) begin
      target = 11'h000;
    end else if (!pwm_reg[`BLD_PWM_EN_BIT]) begin
      target = `BLD_DUTY_FULL;
    end else begin
      target = applied;
    end
  end

  // Step divider: 1 us times two to the selected power per LSB
  assign tick_lim = (12'(`BLD_RAMP_STEP_CYC) << ramp_reg[`BLD_RAMP_SEL_HI:`BLD_RAMP_SEL_LO])
                    - 12'h001;
  assign tick     = (tick_cnt == tick_lim);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 12'h000;
    end else if (!hardware_enable_pin_s || tick) begin
      tick_cnt <= 12'h000;
    end else begin
      tick_cnt <= tick_cnt + 12'h001;
    end
  end

  // One LSB per tick, so a bigger change takes longer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ramp_lvl <= 11'h000;
    end else if (!hardware_enable_pin_s) begin
      ramp_lvl <= 11'h000;
    end else if (tick) begin
      if (ramp_lvl < target) begin
        ramp_lvl <= ramp_lvl + 11'h001;
      end else if (ramp_lvl > target) begin
        ramp_lvl <= ramp_lvl - 11'h001;
      end
    end
  end

  assign prod = 23'(ramp_lvl) * 23'({1'b0, ratio} + 12'h001);

  // Sink level is a held DC value, the ramp level scaled by the ratio, registered every cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sink_level_o  <= 11'h000;
      sink_enable_o <= 1'b0;
    end else if (!hardware_enable_pin_s) begin
      sink_level_o  <= 11'h000;
      sink_enable_o <= 1'b0;
    end else begin
      sink_level_o  <= prod[21:11];
      sink_enable_o <= (prod[21:11] != 11'h000);
    end
  end
endmodule : bld_backlight_ctrl

// *** rtl/bld_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the backlight control
`ifndef BLD_DEFINES_SVH
`define BLD_DEFINES_SVH

// Register offsets on the serial bus
`define BLD_REG_MODE        8'h02
`define BLD_REG_RATIO_LSB   8'h04
`define BLD_REG_RATIO_MSB   8'h05
`define BLD_REG_PWM         8'h06
`define BLD_REG_RAMP        8'h08

// Reset values: full scale code 19 gives the 20.2 mA default
`define BLD_MODE_RESET      8'h98
`define BLD_PWM_RESET       8'h87
`define BLD_RAMP_RESET      8'h00
`define BLD_RATIO_LSB_RESET 8'h07
`define BLD_RATIO_MSB_RESET 8'hff

// Field positions
`define BLD_MODE_BL_BIT     0
`define BLD_MODE_FS_HI      7
`define BLD_MODE_FS_LO      3
`define BLD_PWM_EN_BIT      7
`define BLD_PWM_POL_BIT     6
`define BLD_PWM_HYST_HI     5
`define BLD_PWM_HYST_LO     3
`define BLD_PWM_CH_HI       2
`define BLD_PWM_CH_LO       0
`define BLD_RAMP_SEL_HI     6
`define BLD_RAMP_SEL_LO     4
`define BLD_RATIO_LSB_HI    2

// Serial bus slave address, value arbitrary
`define BLD_I2C_ADDR        7'h2a

// Duty scale and measurement counter width
`define BLD_DUTY_FULL       11'h7ff
`define BLD_DUTY_MUL        18'h007ff
`define BLD_PER_MAX         18'h3ffff

// Timing: clock period and ramp step time
`define BLD_CLK_PERIOD_NS   50
`define BLD_RAMP_STEP_NS    1000
`define BLD_RAMP_STEP_CYC   ((`BLD_RAMP_STEP_NS + `BLD_CLK_PERIOD_NS - 1) / `BLD_CLK_PERIOD_NS)

`endif

// *** rtl/bld_pkg.sv ***
// Types shared by the backlight control modules
package bld_pkg;

  typedef logic [10:0] bld_duty_t;

  typedef enum logic [3:0] {
    BLD_IDLE      = 4'b0000,
    BLD_ADDR      = 4'b0001,
    BLD_ADDR_ACK  = 4'b0010,
    BLD_REG       = 4'b0011,
    BLD_REG_ACK   = 4'b0100,
    BLD_WDATA     = 4'b0101,
    BLD_WDATA_ACK = 4'b0110,
    BLD_RDATA     = 4'b0111,
    BLD_RDATA_ACK = 4'b1000
  } bld_i2c_state_e;

endpackage : bld_pkg

// *** rtl/bld_duty_if.sv ***
// Carrier between the control core and the duty measurement
`timescale 1ns/1ps
interface bld_duty_if;
  logic              enable;
  logic              sample;
  bld_pkg::bld_duty_t duty;
  logic              duty_valid;

  modport meas (input enable, input sample, output duty, output duty_valid);
  modport user (output enable, output sample, input duty, input duty_valid);
endinterface : bld_duty_if

// *** rtl/bld_sync2.sv ***
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module bld_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : bld_sync2

// *** rtl/bld_duty_meas.sv ***
// Measures the input duty per period and divides it to an 11-bit value
`timescale 1ns/1ps
`include "bld_defines.svh"
module bld_duty_meas (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  bld_duty_if.meas  dif
);
  logic        sample_q;
  logic        have_edge;
  logic [17:0] hi_cnt;
  logic [17:0] tot_cnt;
  logic        start;
  logic [17:0] cap_hi;
  logic [17:0] den;
  logic [18:0] rem;
  logic [10:0] num_lo;
  logic [10:0] quo;
  logic [3:0]  it_cnt;
  logic        busy;
  logic [28:0] num;
  logic [18:0] trial;
  logic        rise;

  assign rise  = dif.sample & ~sample_q;
  assign num   = 29'(cap_hi) * 29'(`BLD_DUTY_MUL); // Widen first so the product keeps its top bits
  assign trial = {rem[17:0], num_lo[10]};

  // Period counters, one capture per full input period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_q  <= 1'b0;
      have_edge <= 1'b0;
      hi_cnt    <= 18'h00000;
      tot_cnt   <= 18'h00000;
      start     <= 1'b0;
      cap_hi    <= 18'h00000;
      den       <= 18'h00001;
    end else if (!dif.enable) begin
      sample_q  <= 1'b0;
      have_edge <= 1'b0;
      hi_cnt    <= 18'h00000;
      tot_cnt   <= 18'h00000;
      start     <= 1'b0;
    end else begin
      sample_q <= dif.sample;
      start    <= 1'b0;
      if (rise) begin
        if (have_edge) begin
          cap_hi <= hi_cnt;
          den    <= tot_cnt;
          start  <= 1'b1;
        end
        have_edge <= 1'b1;
        hi_cnt    <= 18'h00001;
        tot_cnt   <= 18'h00001;
      end else begin
        if (tot_cnt != `BLD_PER_MAX) tot_cnt <= tot_cnt + 18'h00001;
        if (dif.sample && hi_cnt != `BLD_PER_MAX) hi_cnt <= hi_cnt + 18'h00001;
        if (tot_cnt == `BLD_PER_MAX) have_edge <= 1'b0; // Stuck level ends the period
      end
    end
  end

  // Bit-serial divider; a stuck input reports 0 or full scale instead
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy           <= 1'b0;
      rem            <= 19'h00000;
      num_lo         <= 11'h000;
      quo            <= 11'h000;
      it_cnt         <= 4'h0;
      dif.duty       <= 11'h000;
      dif.duty_valid <= 1'b0;
    end else begin
      dif.duty_valid <= 1'b0;
      if (!dif.enable) begin
        busy <= 1'b0;
      end else if (start) begin
        busy   <= 1'b1;
        rem    <= {1'b0, num[28:11]};
        num_lo <= num[10:0];
        it_cnt <= 4'hb;
      end else if (busy) begin
        if (trial >= {1'b0, den}) begin
          rem <= trial - {1'b0, den};
          quo <= {quo[9:0], 1'b1};
        end else begin
          rem <= trial;
          quo <= {quo[9:0], 1'b0};
        end
        num_lo <= {num_lo[9:0], 1'b0};
        it_cnt <= it_cnt - 4'h1;
        if (it_cnt == 4'h1) begin
          busy           <= 1'b0;
          dif.duty       <= {quo[9:0], (trial >= {1'b0, den})};
          dif.duty_valid <= 1'b1;
        end
      end else if (tot_cnt == `BLD_PER_MAX - 18'h00001) begin
        dif.duty       <= dif.sample ? `BLD_DUTY_FULL : 11'h000;
        dif.duty_valid <= 1'b1;
      end
    end
  end
endmodule : bld_duty_meas

// *** verif/bld_backlight_ctrl_asserts.sv ***
// Checker of enable, shutdown and sink ramp behaviour at the backlight control ports
`timescale 1ns/1ps
module bld_backlight_ctrl_asserts (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        hardware_enable_pin_i,
  input wire logic        pwm_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [10:0] sink_level_o,
  input wire logic        sink_enable_o,
  input wire logic [4:0]  full_scale_current_o,
  input wire logic [2:0]  channel_enable_o,
  input wire logic        standby_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  logic [4:0] gap;

  // Cycles since the sink level last moved; saturates so a long idle never wraps
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) gap <= 5'h1f;
    else if ($changed(sink_level_o)) gap <= 5'h00;
    else if (gap != 5'h1f) gap <= gap + 5'h01;
  end

  property p_shutdown_quiet;
    !hardware_enable_pin_i [*4] |-> !sda_oe_o;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet)
    else $error("data line pulled while shut down");

  property p_shutdown_defaults;
    !standby_o && !$past(standby_o) |-> full_scale_current_o == 5'h13 && channel_enable_o == 3'h7;
  endproperty
  a_shutdown_defaults: assert property (p_shutdown_defaults)
    else $error("register outputs not at default in shutdown");

  property p_standby_off;
    !hardware_enable_pin_i [*4] |-> !standby_o;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("standby held with enable low");

  property p_standby_on;
    $past(rstn_i, 6) && hardware_enable_pin_i ##1 hardware_enable_pin_i [*3] |-> standby_o;
  endproperty
  a_standby_on: assert property (p_standby_on)
    else $error("standby missing with enable high");

  property p_cut_now;
    $fell(hardware_enable_pin_i) |-> ##[0:3] sink_level_o == 11'h000;
  endproperty
  a_cut_now: assert property (p_cut_now)
    else $error("sink level not cut after enable fall");

  property p_shutdown_dark;
    !standby_o [*2] |-> sink_level_o == 11'h000;
  endproperty
  a_shutdown_dark: assert property (p_shutdown_dark)
    else $error("sink level nonzero in shutdown");

  property p_sink_steady;
    $stable(sink_level_o) |-> sink_enable_o == (sink_level_o != 11'h000);
  endproperty
  a_sink_steady: assert property (p_sink_steady)
    else $error("sink enable disagrees with level");

  property p_ramp_step;
    $changed(sink_level_o) && standby_o && $past(standby_o) |->
      sink_level_o == $past(sink_level_o) + 11'h001 || sink_level_o + 11'h001 == $past(sink_level_o);
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("sink level moved by more than one step");

  property p_ramp_gap;
    $changed(sink_level_o) && standby_o && $past(standby_o) |-> gap >= 5'h13;
  endproperty
  a_ramp_gap: assert property (p_ramp_gap)
    else $error("ramp steps closer than the fastest slope");
endmodule : bld_backlight_ctrl_asserts

bind bld_backlight_ctrl bld_backlight_ctrl_asserts i_bld_backlight_ctrl_asserts (
  .mclk_i, .rstn_i, .hardware_enable_pin_i, .pwm_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .sink_level_o, .sink_enable_o, .full_scale_current_o, .channel_enable_o, .standby_o
);

// *** verif/bld_host_model.sv ***
// Host side model: serial bus master and PWM source with idle line levels
`timescale 1ns/1ps
`include "bld_defines.svh"
module bld_host_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      pwm_o
);
  localparam int Q = 100; // Quarter of the 400 ns bus clock period

  int   pwm_hi = 180;     // High time in 50 ns steps of a 400 step period
  logic pwm_on = 1'b0;

  // 50 kHz source, edges kept off the sampling edges; pulled low when idle
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    pwm_o = 1'b0;
    #13;
    forever begin
      pwm_o = pwm_on;
      #(pwm_hi * 50);
      pwm_o = 1'b0;
      #((400 - pwm_hi) * 50);
    end
  end

  task automatic bit_io(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask : bit_io

  // Ninth bit is always released, so it reads the acknowledge or gives a final refusal
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'b1, n);
    ack = !n;
  endtask : byte_io

  task automatic start_c;
    #13;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop_c

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3;
    start_c();
    byte_io({`BLD_I2C_ADDR, 1'b0}, r, k1);
    byte_io(a, r, k2);
    byte_io(d, r, k3);
    stop_c();
    ok = k1 & k2 & k3;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3, k4;
    start_c();
    byte_io({`BLD_I2C_ADDR, 1'b0}, r, k1);
    byte_io(a, r, k2);
    stop_c();
    start_c();
    byte_io({`BLD_I2C_ADDR, 1'b1}, r, k3);
    byte_io(8'hff, d, k4);
    stop_c();
    ok = k1 & k2 & k3;
  endtask : rd
endmodule : bld_host_model

// *** verif/bld_backlight_ctrl_bench.sv ***
// Self-checking bench: host transfers, PWM dimming and enable sequencing
`timescale 1ns/1ps
module bld_backlight_ctrl_bench;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        hw_en = 1'b0;
  logic        scl, sda_host, sda_line, pwm, sda_out, sda_oe, sink_en, standby, ok;
  logic [10:0] sink_level;
  logic [4:0]  fs_cur;
  logic [2:0]  ch_en;
  logic [7:0]  d;
  int          fail_count = 0;
  int          tests_run = 0;

  always #25 mclk = ~mclk;

  // Open-drain data line with pull-up
  assign sda_line = sda_host & (sda_oe ? sda_out : 1'b1);

  bld_host_model i_bld_host_model (.sda_i(sda_line), .scl_o(scl), .sda_o(sda_host), .pwm_o(pwm));

  bld_backlight_ctrl i_bld_backlight_ctrl (
    .mclk_i(mclk), .rstn_i(rstn), .hardware_enable_pin_i(hw_en), .pwm_i(pwm), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_out), .sda_oe_o(sda_oe), .sink_level_o(sink_level),
    .sink_enable_o(sink_en), .full_scale_current_o(fs_cur), .channel_enable_o(ch_en),
    .standby_o(standby)
  );

  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic check_val(input string name, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  // Bounded wait for the ramp to settle; a spent bound ends the run
  task automatic wait_level(input logic [10:0] exp, input int bound);
    int n = 0;
    while (sink_level !== exp && n < bound) begin
      @(posedge mclk);
      n++;
    end
    check_val("sink_level", exp, sink_level);
    if (n >= bound && sink_level !== exp) stop_test();
  endtask : wait_level

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    i_bld_host_model.wr(8'h02, 8'h99, ok);
    check_val("ack", 11'h000, 11'(ok));
    check_val("full_scale", 11'h013, 11'(fs_cur));
    check_val("standby", 11'h000, 11'(standby));
    @(posedge mclk);
    hw_en <= 1'b1;
    repeat (3000) @(posedge mclk);
    check_val("standby", 11'h001, 11'(standby));
    check_val("channels", 11'h007, 11'(ch_en));
    i_bld_host_model.rd(8'h02, d, ok);
    check_val("mode", 11'h098, 11'(d));
    i_bld_host_model.rd(8'h06, d, ok);
    check_val("dimming", 11'h087, 11'(d));
    check_val("ack", 11'h001, 11'(ok));
    i_bld_host_model.wr(8'h02, 8'ha9, ok);
    check_val("full_scale", 11'h015, 11'(fs_cur));
    i_bld_host_model.rd(8'h0f, d, ok);
    check_val("unmapped", 11'h000, 11'(d));
    $display("test enable and registers done");
    // Widest hysteresis suits the 50 kHz source
    i_bld_host_model.wr(8'h06, 8'hbf, ok);
    i_bld_host_model.pwm_on <= 1'b1;
    wait_level(11'h399, 30000);
    check_val("sink_enable", 11'h001, 11'(sink_en));
    i_bld_host_model.wr(8'h06, 8'hff, ok);
    wait_level(11'h465, 30000);
    $display("test duty and polarity done");
    // Reversal of 5 LSBs is held, 15 LSBs passes, then same direction follows freely
    i_bld_host_model.pwm_hi <= 181;
    repeat (4000) @(posedge mclk);
    check_val("sink_level", 11'h465, sink_level);
    i_bld_host_model.pwm_hi <= 183;
    wait_level(11'h456, 4000);
    i_bld_host_model.pwm_hi <= 184;
    wait_level(11'h451, 4000);
    $display("test hysteresis done");
    // Dimming off: full duty regardless of the input, reached on the slope
    i_bld_host_model.wr(8'h06, 8'h7f, ok);
    wait_level(11'h7ff, 20000);
    $display("test dimming off done");
    i_bld_host_model.wr(8'h02, 8'ha8, ok);
    repeat (200) @(posedge mclk);
    check_val("ramping", 11'h001, 11'(sink_level < 11'h7ff && sink_level != 11'h000));
    i_bld_host_model.rd(8'h02, d, ok);
    check_val("mode", 11'h0a8, 11'(d));
    check_val("ack", 11'h001, 11'(ok));
    @(posedge mclk);
    hw_en <= 1'b0;
    repeat (4) @(posedge mclk);
    check_val("sink_level", 11'h000, sink_level);
    check_val("full_scale", 11'h013, 11'(fs_cur));
    i_bld_host_model.rd(8'h02, d, ok);
    check_val("ack", 11'h000, 11'(ok));
    @(posedge mclk);
    hw_en <= 1'b1;
    repeat (3000) @(posedge mclk);
    i_bld_host_model.rd(8'h02, d, ok);
    check_val("mode", 11'h098, 11'(d));
    $display("test turn off done");
    stop_test();
  end
endmodule : bld_backlight_ctrl_bench
